// ==== rtl/tlc_filt.sv ====
// first-order spike filter for the first external channel
// assumes take pulses once per accepted conversion
`timescale 1ns/1ps
module tlc_filt #(
  parameter int RAW_W = tlc_pkg::RAW_W_DEF
) (
  input  logic                    clock,
  input  logic                    rst_sn,
  input  logic [1:0]              sel,
  input  logic                    take,
  input  logic signed [RAW_W-1:0] x,
  output logic signed [RAW_W-1:0] y
);
  typedef struct packed {
    logic                    primed;
    logic signed [RAW_W+2:0] acc;
  } tlc_filt_st_t;

  tlc_filt_st_t          st_ff;
  tlc_filt_st_t          nxt_st;
  logic signed [RAW_W+2:0] xs;
  logic signed [RAW_W+3:0] diff;
  logic signed [RAW_W+3:0] step;
  logic signed [RAW_W+2:0] upd;

  always_comb begin
    nxt_st = st_ff;
    xs     = {x, 3'h0};
    diff   = {xs[RAW_W+2], xs} - {st_ff.acc[RAW_W+2], st_ff.acc};
    step   = (sel == 2'h3) ? (diff >>> tlc_pkg::FILT_SH2) : (diff >>> tlc_pkg::FILT_SH1);
    // unprimed start avoids ramping up from zero after reset
    if (sel == 2'h0 || !st_ff.primed) begin
      upd = xs;
    end else begin
      upd = st_ff.acc + step[RAW_W+2:0];
    end
    y = upd[RAW_W+2:3];
    if (take) begin
      nxt_st.acc    = upd;
      nxt_st.primed = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ==== rtl/tlc_fmt.sv ====
// formats a signed eighth-degree reading into the 11-bit result code
// assumes raw readings are two's complement with three fraction bits
`timescale 1ns/1ps
module tlc_fmt #(
  parameter int RAW_W = tlc_pkg::RAW_W_DEF
) (
  input  logic signed [RAW_W-1:0]          raw,
  input  logic                             ext_range,
  input  logic                             fault,
  output logic [tlc_pkg::RES_W-1:0]        res
);
  logic signed [RAW_W:0] wide;
  logic signed [RAW_W:0] ofs;
  logic signed [RAW_W:0] sel;
  logic [10:0]           top;

  always_comb begin
    wide = {raw[RAW_W-1], raw};
    ofs  = wide + $signed({{(RAW_W-12){1'b0}}, tlc_pkg::EXT_OFS});
    sel  = ext_range ? ofs : wide;
    top  = ext_range ? tlc_pkg::EXT_MAX : tlc_pkg::DEF_MAX;
    if (fault || sel[RAW_W]) begin
      res = '0;
    end else if (sel > $signed({{(RAW_W-10){1'b0}}, top})) begin
      res = top;
    end else begin
      res = sel[10:0];
    end
  end
endmodule

// ==== rtl/tlc_pkg.sv ====
// constants shared by the temperature limit compare and status block
// assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data
package tlc_pkg;
  localparam int NCH_DEF   = 4;
  localparam int RAW_W_DEF = 13;
  localparam int RES_W     = 11;
  localparam int AW        = 12;

  localparam logic [11:0] A_STATUS  = 12'h000;
  localparam logic [11:0] A_CONFIG  = 12'h004;
  localparam logic [11:0] A_ONESHOT = 12'h008;
  localparam logic [11:0] A_HSTAT   = 12'h00C;
  localparam logic [11:0] A_LSTAT   = 12'h010;
  localparam logic [11:0] A_CSTAT   = 12'h014;
  localparam logic [11:0] A_FSTAT   = 12'h018;
  localparam logic [11:0] A_MASK    = 12'h01C;
  localparam logic [11:0] A_CONSEC  = 12'h020;
  localparam logic [11:0] A_HYST    = 12'h024;
  localparam logic [11:0] A_LIM0    = 12'h040;
  localparam logic [11:0] A_LIM1    = 12'h080;
  localparam logic [11:0] A_RES     = 12'h100;

  localparam int CFG_EXT  = 0;
  localparam int CFG_CMP  = 1;
  localparam int CFG_HALT = 2;
  localparam int CFG_FILT = 3;
  localparam int CFG_MALL = 5;
  localparam int ST_CRIT  = 0;
  localparam int ST_FAULT = 2;
  localparam int ST_LOW   = 3;
  localparam int ST_HIGH  = 4;

  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [10:0] HLIM_RST   = 11'h3FF;
  localparam logic [10:0] LLIM_RST   = 11'h000;
  localparam logic [10:0] CLIM_RST   = 11'h3FF;
  localparam logic [7:0]  HYST_RST   = 8'h0A;
  localparam logic [2:0]  CONSEC_RST = 3'h0;

  localparam logic [10:0] DEF_MAX  = 11'h3FF;
  localparam logic [10:0] EXT_MAX  = 11'h7FF;
  localparam logic [12:0] EXT_OFS  = 13'h0200;
  localparam int          FILT_SH1 = 2;
  localparam int          FILT_SH2 = 3;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // consecutive count code to number of measurements
  function automatic logic [2:0] consec_need(input logic [2:0] code);
    case (code)
      3'h1:    consec_need = 3'h2;
      3'h3:    consec_need = 3'h3;
      3'h7:    consec_need = 3'h4;
      default: consec_need = 3'h1;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction
endpackage

// ==== rtl/tlc_temp_limit.sv ====
// result formatting, limit compare, status bits and alert/critical pins
// assumes conversion logic on the same clock presents readings with conv_done
`timescale 1ns/1ps

module tlc_temp_limit #(
  parameter int NCH   = tlc_pkg::NCH_DEF,
  parameter int RAW_W = tlc_pkg::RAW_W_DEF
) (
  input  logic                               clock,
  input  logic                               rst_n,
  input  logic [tlc_pkg::AW-1:0]             awaddr,
  input  logic                               awvalid,
  output logic                               awready,
  input  logic [31:0]                        wdata,
  input  logic [3:0]                         wstrb,
  input  logic                               wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  logic                               bready,
  input  logic [tlc_pkg::AW-1:0]             araddr,
  input  logic                               arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  logic                               rready,
  input  logic                               conv_done,
  input  logic [NCH-1:0][RAW_W-1:0]          raw_temp,
  input  logic [NCH-1:1]                     diode_fault,
  output logic                               conv_req,
  output logic                               alert_out_pin_n,
  output logic                               crit_pin_n
);
  localparam int AW = tlc_pkg::AW;

  typedef struct packed {
    logic [7:0]             cfg;
    logic                   pend;
    logic [NCH-1:0]         mask;
    logic [2:0]             consec;
    logic [7:0]             hyst;
    logic [NCH-1:0][10:0]   hlim;
    logic [NCH-1:0][10:0]   llim;
    logic [NCH-1:0][10:0]   clim;
    logic [NCH-1:0][10:0]   res;
    logic [NCH-1:0]         hst;
    logic [NCH-1:0]         lst;
    logic [NCH-1:0]         cst;
    logic [NCH-1:0]         fst;
    logic [NCH-1:0][2:0]    cnt;
    logic                   alert_n;
    logic                   crit_n;
    logic                   aw_got;
    logic [AW-1:0]          awaddr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } tlc_state_t;

  localparam tlc_state_t ST_RST = '{cfg:     tlc_pkg::CFG_RST,
                                    consec:  tlc_pkg::CONSEC_RST,
                                    hyst:    tlc_pkg::HYST_RST,
                                    hlim:    {NCH{tlc_pkg::HLIM_RST}},
                                    llim:    {NCH{tlc_pkg::LLIM_RST}},
                                    clim:    {NCH{tlc_pkg::CLIM_RST}},
                                    alert_n: 1'b1,
                                    crit_n:  1'b1,
                                    default: '0};

  logic [1:0]             rsync_ff;
  logic                   rst_sn;
  tlc_state_t             st_ff;
  tlc_state_t             nxt_st;
  logic [NCH-1:0][10:0]   fmt_res;
  logic [NCH-1:0]         flt;
  logic [NCH-1:0]         hi_v;
  logic [NCH-1:0]         lo_v;
  logic [NCH-1:0]         cr_v;
  logic [NCH-1:0]         hi_clr;
  logic [NCH-1:0]         cr_clr;
  logic [NCH-1:0][2:0]    cnt1;
  logic [NCH-1:0]         fire;
  logic signed [RAW_W-1:0] filt_y;
  logic [10:0]            hyst11;
  logic [2:0]             need;
  logic                   run;
  logic                   acc;
  logic                   cmp;
  logic                   ar_hs;
  logic                   rd_h;
  logic                   rd_l;
  logic                   rd_f;
  logic [32:0]            rv;
  logic [32:0]            wv;
  logic [31:0]            mw;
  logic [AW-1:0]          wa;
  logic                   alert_any;

  // reset released through two stages, asserted at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsync_ff <= 2'h0;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end
  assign rst_sn = rsync_ff[1];

  function automatic logic lim_hit(input logic [AW-1:0] a);
    lim_hit = (a[AW-1:8] == '0) && (a[7:6] == 2'h1 || a[7:6] == 2'h2) &&
              (a[3:2] != 2'h3) && (32'(a[5:4]) < NCH) && (a[1:0] == 2'h0);
  endfunction

  // returns {mapped, word}; both limit windows decode to the same storage
  function automatic logic [32:0] rd_val(input tlc_state_t s, input logic [AW-1:0] a);
    logic [31:0] w;
    logic        ok;
    w  = '0;
    ok = 1'b1;
    if (lim_hit(a)) begin
      unique case (a[3:2])
        2'h0:    w[10:0] = s.hlim[a[5:4]];
        2'h1:    w[10:0] = s.llim[a[5:4]];
        default: w[10:0] = s.clim[a[5:4]];
      endcase
    end else if (a[AW-1:4] == tlc_pkg::A_RES[AW-1:4] && 32'(a[3:2]) < NCH) begin
      w[15:0] = {s.res[a[3:2]][10:3], s.res[a[3:2]][2:0], 5'h00};
    end else begin
      case (a)
        tlc_pkg::A_STATUS: begin
          w[tlc_pkg::ST_HIGH]  = |s.hst;
          w[tlc_pkg::ST_LOW]   = |s.lst;
          w[tlc_pkg::ST_FAULT] = |s.fst;
          w[tlc_pkg::ST_CRIT]  = |s.cst;
        end
        tlc_pkg::A_CONFIG:  w[7:0]     = s.cfg;
        tlc_pkg::A_ONESHOT: w          = '0;
        tlc_pkg::A_HSTAT:   w[NCH-1:0] = s.hst;
        tlc_pkg::A_LSTAT:   w[NCH-1:0] = s.lst;
        tlc_pkg::A_CSTAT:   w[NCH-1:0] = s.cst;
        tlc_pkg::A_FSTAT:   w[NCH-1:0] = s.fst;
        tlc_pkg::A_MASK:    w[NCH-1:0] = s.mask;
        tlc_pkg::A_CONSEC:  w[2:0]     = s.consec;
        tlc_pkg::A_HYST:    w[7:0]     = s.hyst;
        default:            ok         = 1'b0;
      endcase
    end
    rd_val = {ok, w};
  endfunction

  tlc_filt #(.RAW_W(RAW_W)) u_filt (
    .clock  (clock),
    .rst_sn (rst_sn),
    .sel    (st_ff.cfg[tlc_pkg::CFG_FILT +: 2]),
    .take   (acc),
    .x      (raw_temp[1]),
    .y      (filt_y)
  );

  assign hyst11 = {st_ff.hyst, 3'h0};
  assign need   = tlc_pkg::consec_need(st_ff.consec);

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // the internal diode has no fault detection
    if (g == 0) begin : g_int
      assign flt[g] = 1'b0;
    end else begin : g_ext
      assign flt[g] = diode_fault[g];
    end
    tlc_fmt #(.RAW_W(RAW_W)) u_fmt (
      .raw       ((g == 1) ? filt_y : raw_temp[g]),
      .ext_range (st_ff.cfg[tlc_pkg::CFG_EXT]),
      .fault     (flt[g]),
      .res       (fmt_res[g])
    );
    assign hi_v[g]   = fmt_res[g] > st_ff.hlim[g];
    assign lo_v[g]   = !flt[g] && (fmt_res[g] <= st_ff.llim[g]);
    assign cr_v[g]   = fmt_res[g] > st_ff.clim[g];
    assign hi_clr[g] = ({1'b0, fmt_res[g]} + {1'b0, hyst11}) < {1'b0, st_ff.hlim[g]};
    assign cr_clr[g] = ({1'b0, fmt_res[g]} + {1'b0, hyst11}) < {1'b0, st_ff.clim[g]};
    assign cnt1[g]   = st_ff.cnt[g] + 3'h1;
    assign fire[g]   = cnt1[g] >= need;
  end

  assign run     = !st_ff.cfg[tlc_pkg::CFG_HALT];
  assign cmp     = st_ff.cfg[tlc_pkg::CFG_CMP];
  assign acc     = conv_done && (run || st_ff.pend);
  assign awready = !st_ff.aw_got && !st_ff.bvalid;
  assign wready  = !st_ff.w_got && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign ar_hs   = arvalid && arready;
  assign rd_h    = ar_hs && (araddr == tlc_pkg::A_HSTAT);
  assign rd_l    = ar_hs && (araddr == tlc_pkg::A_LSTAT);
  assign rd_f    = ar_hs && (araddr == tlc_pkg::A_FSTAT);

  always_comb begin
    nxt_st = st_ff;
    rv     = rd_val(st_ff, araddr);
    wa     = st_ff.awaddr;
    wv     = rd_val(st_ff, wa);
    mw     = tlc_pkg::merge(wv[31:0], st_ff.wdata, st_ff.wstrb);
    if (awvalid && awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata;
      nxt_st.wstrb = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // clear before set so an event in the read cycle survives
    if (rd_h) begin
      nxt_st.hst = '0;
    end
    if (rd_l) begin
      nxt_st.lst = '0;
    end
    if (rd_f) begin
      nxt_st.fst = '0;
    end
    if (acc) begin
      nxt_st.pend = 1'b0;
      for (int i = 0; i < NCH; i++) begin
        nxt_st.res[i] = fmt_res[i];
        if (cmp) begin
          // comparator: counter only watches the high limit
          nxt_st.lst[i] = lo_v[i];
          if (hi_v[i]) begin
            if (fire[i] || st_ff.hst[i]) begin
              nxt_st.hst[i] = 1'b1;
            end else begin
              nxt_st.cnt[i] = cnt1[i];
            end
          end else if (hi_clr[i]) begin
            nxt_st.hst[i] = 1'b0;
            nxt_st.cnt[i] = 3'h0;
          end
          if (flt[i]) begin
            nxt_st.fst[i] = 1'b1;
          end
        end else if (hi_v[i] || lo_v[i] || flt[i]) begin
          if (fire[i]) begin
            nxt_st.hst[i] = nxt_st.hst[i] | hi_v[i];
            nxt_st.lst[i] = nxt_st.lst[i] | lo_v[i];
            nxt_st.fst[i] = nxt_st.fst[i] | flt[i];
            nxt_st.cnt[i] = 3'h0;
          end else begin
            nxt_st.cnt[i] = cnt1[i];
          end
        end else begin
          nxt_st.cnt[i] = 3'h0;
        end
        if (cr_v[i]) begin
          nxt_st.cst[i] = 1'b1;
        end else if (cr_clr[i]) begin
          nxt_st.cst[i] = 1'b0;
        end
      end
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wv[32] ? tlc_pkg::RESP_OK : tlc_pkg::RESP_ERR;
      if (lim_hit(wa)) begin
        // new limits act at the next accepted conversion only
        unique case (wa[3:2])
          2'h0:    nxt_st.hlim[wa[5:4]] = mw[10:0];
          2'h1:    nxt_st.llim[wa[5:4]] = mw[10:0];
          default: nxt_st.clim[wa[5:4]] = mw[10:0];
        endcase
      end else begin
        case (wa)
          tlc_pkg::A_CONFIG:  nxt_st.cfg    = mw[7:0];
          tlc_pkg::A_ONESHOT: nxt_st.pend   = 1'b1;
          tlc_pkg::A_MASK:    nxt_st.mask   = mw[NCH-1:0];
          tlc_pkg::A_CONSEC:  nxt_st.consec = mw[2:0];
          tlc_pkg::A_HYST:    nxt_st.hyst   = mw[7:0];
          default:            nxt_st.cfg    = nxt_st.cfg;
        endcase
      end
    end
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rv[31:0];
      nxt_st.rresp  = rv[32] ? tlc_pkg::RESP_OK : tlc_pkg::RESP_ERR;
    end
    // comparator mode ignores low and fault for the pin
    if (cmp) begin
      alert_any = |(nxt_st.hst & ~nxt_st.mask);
    end else begin
      alert_any = |((nxt_st.hst | nxt_st.lst | nxt_st.fst) & ~nxt_st.mask);
    end
    nxt_st.alert_n = !(alert_any && !nxt_st.cfg[tlc_pkg::CFG_MALL]);
    nxt_st.crit_n  = !(|nxt_st.cst);
  end

  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bvalid          = st_ff.bvalid;
  assign bresp           = st_ff.bresp;
  assign rvalid          = st_ff.rvalid;
  assign rdata           = st_ff.rdata;
  assign rresp           = st_ff.rresp;
  assign conv_req        = run || st_ff.pend;
  assign alert_out_pin_n = st_ff.alert_n;
  assign crit_pin_n      = st_ff.crit_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sn);

  chk_high_set: assert property (acc && !cmp && fire[0] && hi_v[0] |=> st_ff.hst[0])
    else $error("high status not set");
  chk_low_set: assert property (acc && !cmp && fire[0] && lo_v[0] |=> st_ff.lst[0])
    else $error("low status not set");
  chk_alias_read: assert property (ar_hs && araddr == tlc_pkg::A_LIM1 ##1 1'b1 |->
                                   rdata[10:0] == $past(st_ff.hlim[0]))
    else $error("alias limit read mismatch");
  chk_standby_hold: assert property (!run && !st_ff.pend && conv_done |=>
                                     $stable(st_ff.res))
    else $error("standby conversion changed results");
  chk_crit_pin: assert property (acc && cr_v[0] |=> st_ff.cst[0] && !crit_pin_n)
    else $error("critical pin not asserted");
  chk_crit_keep: assert property (ar_hs && araddr == tlc_pkg::A_CSTAT && st_ff.cst[0]
                                  && !acc |=> st_ff.cst[0])
    else $error("critical bit cleared by read");
  chk_high_rdclr: assert property (rd_h && !acc |=> st_ff.hst == '0)
    else $error("high status survived read");
  chk_low_rdclr: assert property (rd_l && !acc |=> st_ff.lst == '0)
    else $error("low status survived read");
  chk_alert_cause: assert property ($fell(alert_out_pin_n) |->
                                    $past(acc) || $past(st_ff.aw_got && st_ff.w_got))
    else $error("alert asserted without cause");
  chk_crit_nomask: assert property (|st_ff.cst |=> !crit_pin_n || $past(acc))
    else $error("critical pin masked");
  chk_mask_alert: assert property (&st_ff.mask ##1 &st_ff.mask |-> alert_out_pin_n)
    else $error("masked channel drove alert");
  chk_filter_off: assert property (st_ff.cfg[tlc_pkg::CFG_FILT +: 2] == 2'h0 |->
                                   filt_y == raw_temp[1])
    else $error("filter not bypassed");
  chk_sticky_high: assert property (!cmp && st_ff.hst[0] && !rd_h |=> st_ff.hst[0])
    else $error("high status lost");
  chk_def_clamp: assert property (acc && !st_ff.cfg[tlc_pkg::CFG_EXT] &&
                                  raw_temp[0][RAW_W-1] |=> st_ff.res[0] == 11'h000)
    else $error("default range low clamp");
  chk_ext_zero: assert property (acc && st_ff.cfg[tlc_pkg::CFG_EXT] && raw_temp[0] == '0
                                 |=> st_ff.res[0] == tlc_pkg::EXT_OFS[10:0])
    else $error("extended offset wrong");
  chk_fault_zero: assert property (acc && flt[1] && (fire[1] || cmp) |=>
                                   st_ff.res[1] == '0 && st_ff.fst[1])
    else $error("fault result not zero");
  chk_consec_wait: assert property (acc && !cmp && need == 3'h2 && st_ff.cnt[0] == 3'h0 &&
                                    hi_v[0] && !st_ff.hst[0] |=>
                                    !st_ff.hst[0] && st_ff.cnt[0] == 3'h1)
    else $error("consecutive count skipped");

  cov_alert: cover property ($fell(alert_out_pin_n));
  cov_crit: cover property ($fell(crit_pin_n));
  cov_cmp_high: cover property (cmp && acc && hi_v[0] ##1 st_ff.hst[0]);
  cov_alias_wr: cover property (st_ff.aw_got && st_ff.w_got && st_ff.awaddr == tlc_pkg::A_LIM1);
endmodule

// ==== sim/temp_limit_compare_status_tb_top.sv ====
// self-checking bench: formatting rows, limits, status, pins, bus errors
// assumes a 20 MHz clock and the conversion model tlc_conv_src
`timescale 1ns/1ps
module temp_limit_compare_status_tb_top;
  typedef struct {logic ext; logic [12:0] raw; logic [10:0] res;} tlc_row_t;
  logic        clock = 0, rst_n = 0, go = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 1, rready = 1, awready, wready, bvalid, arready, rvalid;
  logic        conv_done, conv_req, alert_out_pin_n, crit_pin_n;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rd_r;
  logic [12:0] temp = 0;
  logic [3:1]  fault = 0, diode_fault;
  logic [3:0][12:0] raw_temp;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  tlc_row_t    rows[8] = '{'{0, 13'h1FF8, 11'h000}, '{0, 13'h0001, 11'h001},
    '{0, 13'h03FF, 11'h3FF}, '{0, 13'h0400, 11'h3FF}, '{1, 13'h1DFF, 11'h000},
    '{1, 13'h1FFF, 11'h1FF}, '{1, 13'h0000, 11'h200}, '{1, 13'h0FFF, 11'h7FF}};

  tlc_conv_src src (.clock, .go, .temp, .fault, .conv_done, .raw_temp, .diode_fault);
  tlc_temp_limit dut (.clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .conv_done, .raw_temp, .diode_fault, .conv_req,
    .alert_out_pin_n, .crit_pin_n);

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // bready and rready stay high, so only the request side is handshaked here
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(negedge clock);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rd_r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(negedge clock);
      ta = arready;
      tr = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 0;
    end while (!tr);
  endtask
  task automatic cv(input logic [12:0] t, input logic [3:1] f);
    temp <= t;
    fault <= f;
    go <= 1;
    @(posedge clock);
    go <= 0;
    repeat (3) @(posedge clock);
  endtask

  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    repeat (3) @(posedge clock);
    rd(tlc_pkg::A_CONFIG);
    ck(rd_d, 0);
    foreach (rows[i]) begin
      wr(tlc_pkg::A_CONFIG, {31'h0, rows[i].ext});
      cv(rows[i].raw, 0);
      rd(tlc_pkg::A_RES);
      ck(rd_d, {16'h0, rows[i].res, 5'h0});
    end
    wr(tlc_pkg::A_CONFIG, 0);
    rd(tlc_pkg::A_LSTAT);
    ck(rd_d, 32'hF);
    rd(tlc_pkg::A_LSTAT);
    ck(rd_d, 0);
    rd(tlc_pkg::A_HSTAT);
    ck(rd_d, 32'hF);
    ck(alert_out_pin_n, 1);
    $display("done: format rows");
    wr(tlc_pkg::A_LIM1, 32'h100);
    rd(tlc_pkg::A_LIM0);
    ck(rd_d, 32'h100);
    cv(13'h101, 0);
    ck(alert_out_pin_n, 0);
    rd(tlc_pkg::A_STATUS);
    ck(rd_d[4], 1);
    rd(tlc_pkg::A_HSTAT);
    ck(rd_d, 1);
    rd(tlc_pkg::A_HSTAT);
    ck(rd_d, 0);
    wr(tlc_pkg::A_CONSEC, 1);
    cv(13'h101, 0);
    ck(alert_out_pin_n, 1);
    cv(13'h101, 0);
    ck(alert_out_pin_n, 0);
    rd(tlc_pkg::A_HSTAT);
    ck(rd_d, 1);
    wr(tlc_pkg::A_CONSEC, 0);
    $display("done: high limit");
    wr(tlc_pkg::A_MASK, 1);
    wr(tlc_pkg::A_LIM0 + 12'h8, 32'h100);
    cv(13'h101, 0);
    ck(alert_out_pin_n, 1);
    ck(crit_pin_n, 0);
    rd(tlc_pkg::A_CSTAT);
    rd(tlc_pkg::A_CSTAT);
    ck(rd_d, 1);
    cv(13'h0B0, 0);
    ck(crit_pin_n, 0);
    cv(13'h0AF, 0);
    ck(crit_pin_n, 1);
    $display("done: critical and mask");
    cv(13'h050, 3'b001);
    ck(alert_out_pin_n, 0);
    rd(tlc_pkg::A_RES + 12'h4);
    ck(rd_d, 0);
    rd(tlc_pkg::A_LSTAT);
    ck(rd_d[1], 0);
    wr(tlc_pkg::A_MASK, 32'hF);
    ck(alert_out_pin_n, 1);
    wr(tlc_pkg::A_CONFIG, 32'h4);
    ck(conv_req, 0);
    wr(tlc_pkg::A_LIM0, 32'h000);
    cv(13'h060, 0);
    rd(tlc_pkg::A_RES);
    ck(rd_d, 32'h0A00);
    wr(tlc_pkg::A_ONESHOT, 1);
    ck(conv_req, 1);
    cv(13'h060, 0);
    rd(tlc_pkg::A_RES);
    ck(rd_d, 32'h0C00);
    wr(tlc_pkg::A_CONFIG, 32'h08);
    cv(13'h0A0, 0);
    rd(tlc_pkg::A_RES + 12'h4);
    ck(rd_d, 32'h0E00);
    wr(tlc_pkg::A_CONFIG, 32'h18);
    cv(13'h0A0, 0);
    rd(tlc_pkg::A_RES + 12'h4);
    ck(rd_d, 32'h0EC0);
    rd(12'h04C);
    ck(rd_r, tlc_pkg::RESP_ERR);
    wr(12'h04C, 0);
    ck(rd_r, tlc_pkg::RESP_ERR);
    $display("done: fault, standby, bus");
    report_and_stop;
  end
endmodule

// ==== sim/tlc_conv_src.sv ====
// conversion source model feeding the limit block
// assumes the bench pulses go for one cycle per wanted conversion
`timescale 1ns/1ps
module tlc_conv_src #(
  parameter int NCH   = 4,
  parameter int RAW_W = 13
) (
  input  logic                     clock,
  input  logic                     go,
  input  logic [RAW_W-1:0]         temp,
  input  logic [NCH-1:1]           fault,
  output logic                     conv_done,
  output logic [NCH-1:0][RAW_W-1:0] raw_temp,
  output logic [NCH-1:1]           diode_fault
);
  // finishes even in standby, so the block's own gating is what gets exercised
  initial begin
    conv_done   = 1'b0;
    raw_temp    = '0;
    diode_fault = '0;
  end
  // data off the strobe is scrambled so the block cannot lean on stale values
  always @(posedge clock) begin
    conv_done   <= go;
    raw_temp    <= go ? {NCH{temp}} : ~raw_temp;
    diode_fault <= go ? fault : ~diode_fault;
  end
endmodule
